// ### core/tatc_defines.svh
`ifndef TATC_DEFINES_SVH
`define TATC_DEFINES_SVH

// Register byte offsets on the AHB-Lite slave.
`define TATC_CTRL_OFS        8'h00
`define TATC_STATUS_OFS      8'h04
`define TATC_ODEM_OFS        8'h08
`define TATC_MEMCFG_OFS      8'h0c
`define TATC_MEMSTAT_OFS     8'h10

// Control register fields.
`define TATC_CTRL_MODE_LSB   0
`define TATC_CTRL_EDGE_EN    2
`define TATC_CTRL_CRIT_EN    3
`define TATC_MODE_CODE_OUT   2'h1
`define TATC_MODE_CODE_BIDIR 2'h2

// Status register fields.
`define TATC_ST_ALERT        0
`define TATC_ST_LOWPERF      1
`define TATC_ST_CRIT         2
`define TATC_ST_CRIT_STICKY  3
`define TATC_ST_EV_ASSERT    4
`define TATC_ST_EV_DEASSERT  5
`define TATC_ST_TRIP         6
`define TATC_ST_DRIVE        7
`define TATC_ST_DEMOTE_LSB   8

// On-demand clock modulation fields.
`define TATC_OD_MSR_EN       0
`define TATC_OD_MSR_DUTY_LSB 1
`define TATC_OD_IO_EN        4
`define TATC_OD_IO_DUTY_LSB  5

// Memory throttle fields.
`define TATC_MC_WARM_LSB     0
`define TATC_MC_HOT_LSB      8
`define TATC_MC_WARM_AMT_LSB 16
`define TATC_MC_HOT_AMT_LSB  20
`define TATC_MS_LEVEL_LSB    0
`define TATC_MS_AMT_LSB      4
`define TATC_MS_REFRESH      8

// Reset values.
`define TATC_WARM_RST        8'h55
`define TATC_HOT_RST         8'h5f
`define TATC_WARM_AMT_RST    4'h4
`define TATC_HOT_AMT_RST     4'hf

// Fixed factory duty of the thermal control circuit, in eighths of on time.
`define TATC_TCC_DUTY        3'h2
`define TATC_MR3_HOT_CODE    2'h2
`define TATC_DEMOTE_THRESH   4'h3
`define TATC_DEMOTE_MAX      4'hf
`define TATC_RELEASE_GUARD   3'h4

// Timing.
`define TATC_CLK_MHZ          125
`define TATC_RESP_LIMIT_US    100
`define TATC_FAST_LIMIT_US    10
`define TATC_CONSEC_WINDOW_US 1000
`define TATC_RESP_LIMIT_CYC   ((`TATC_RESP_LIMIT_US) * (`TATC_CLK_MHZ))
`define TATC_FAST_LIMIT_CYC   ((`TATC_FAST_LIMIT_US) * (`TATC_CLK_MHZ))
`define TATC_CONSEC_WIN_CYC   ((`TATC_CONSEC_WINDOW_US) * (`TATC_CLK_MHZ))

`endif

// ### core/tatc_pkg.sv
package tatc_pkg;

    typedef enum logic [1:0] {
        TATC_MODE_IN,
        TATC_MODE_OUT,
        TATC_MODE_BIDIR
    } tatc_mode_e;

    typedef enum logic {
        TATC_AL_IDLE,
        TATC_AL_HELD
    } tatc_alert_e;

    typedef struct packed {
        logic       en;
        logic [2:0] duty;
        logic       all_cores;
    } tatc_clkmod_s;

    typedef struct packed {
        logic [1:0] level;
        logic [3:0] amount;
        logic       refresh_double;
    } tatc_mem_s;

    typedef struct packed {
        logic         dp_wr;
        logic         dp_rd;
        logic         rd_rdy;
        logic [7:0]   dp_addr;
        logic [31:0]  hrdata;
        tatc_mode_e   mode;
        logic         edge_en;
        logic         crit_en;
        logic         msr_en;
        logic [2:0]   msr_duty;
        logic         io_en;
        logic [2:0]   io_duty;
        logic [7:0]   warm;
        logic [7:0]   hot;
        logic [3:0]   warm_amt;
        logic [3:0]   hot_amt;
        tatc_alert_e  alert_st;
        logic         ev_assert;
        logic         ev_deassert;
        logic         crit;
        logic         crit_sticky;
        logic         trip;
        logic         drive;
        logic [2:0]   guard;
        logic [3:0]   consec;
        logic [23:0]  win;
        logic [3:0]   demote;
        tatc_clkmod_s clkmod;
        tatc_mem_s    mem;
    } tatc_state_s;

endpackage

// ### core/tatc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage pin synchroniser; the output moves only when stages two and three agree.
module tatc_pin_sync #(
    parameter logic IDLE_LEVEL = 1'b1
) (
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    input  wire logic pin_in,
    output var  logic level_out
);
    logic [2:0] stage;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            stage     <= {3{IDLE_LEVEL}};
            level_out <= IDLE_LEVEL;
        end else begin
            stage <= {stage[1:0], pin_in};
            if (stage[1] == stage[2]) begin
                level_out <= stage[2];
            end
        end
    end
endmodule // tatc_pin_sync

`default_nettype wire

// ### core/tatc_core.sv
// Notes on behaviour
// - Alert pin mode is input, output or bidirectional; input after reset.
// - External alert forces lowest performance state for cores and graphics at once.
// - External alert never starts clock modulation.
// - Lowest performance state holds until the external alert is released.
// - Optional interrupt on alert assertion and deassertion edges.
// - While the device drives the pin, external sensing waits for release.
// - External alert response completes well under 100 us.
// - Consecutive external alerts step the frequency cap down; quiet steps it up.
// - Demotion works only in input-only mode.
// - Driven alert drops in package idle and returns on wake if hot.
// - Damaging temperature shuts the package down and asserts trip output.
// - Critical temperature during thermal response latches status, sticky bit, interrupt.
// - Software forces clock modulation; circuit duty overrides it while engaged.
// - Legacy I/O on-demand duty wins over the register path duty.
// - Legacy I/O on-demand request modulates all cores together.
// - Memory throttling at warm and hot thresholds, amount set by level.
// - DRAM die temperature from MR3 sets the refresh rate.
// - Input-only alert halves core frequency within 10 us.
`include "tatc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tatc_core #(
    parameter int CONSEC_WINDOW_CYC = `TATC_CONSEC_WIN_CYC
) (
    input  wire logic                 clk_in,
    input  wire logic                 sys_rst_in,
    input  wire logic                 hsel_in,
    input  wire logic [31:0]          haddr_in,
    input  wire logic [1:0]           htrans_in,
    input  wire logic                 hwrite_in,
    input  wire logic [2:0]           hsize_in,
    input  wire logic [31:0]          hwdata_in,
    input  wire logic                 hready_in,
    output var  logic [31:0]          hrdata_out,
    output var  logic                 hreadyout_out,
    output var  logic                 hresp_out,
    input  wire logic                 thermal_alert_n_in,
    output var  logic                 thermal_alert_n_out,
    output var  logic                 thermal_alert_n_oe_out,
    input  wire logic                 tcc_active_in,
    input  wire logic                 tcc_clkmod_in,
    input  wire logic                 pkg_idle_in,
    input  wire logic                 crit_temp_in,
    input  wire logic                 trip_temp_in,
    input  wire logic [7:0]           mem_temp_in,
    input  wire logic                 mr3_valid_in,
    input  wire logic [1:0]           mr3_temp_in,
    output var  logic                 lowest_perf_state_out,
    output var  logic                 fast_half_freq_out,
    output var  logic [3:0]           freq_demote_out,
    output var  logic                 edge_irq_out,
    output var  logic                 thermal_irq_out,
    output var  logic                 overtemp_trip_n_out,
    output var  logic                 pkg_shutdown_out,
    output var  tatc_pkg::tatc_clkmod_s clkmod_out,
    output var  tatc_pkg::tatc_mem_s  mem_throttle_out
);
    import tatc_pkg::*;

    tatc_state_s st;
    tatc_state_s next_st;
    logic        alert_n_filt;
    logic        alert_ext;
    logic        acc;

    tatc_pin_sync #(
        .IDLE_LEVEL (1'b1)
    ) u_alert_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (thermal_alert_n_in),
        .level_out  (alert_n_filt)
    );

    // The pin is masked while we drive it and briefly after, so our own low cannot echo back.
    assign alert_ext = (st.mode != TATC_MODE_OUT) && !alert_n_filt && !st.drive
                       && (st.guard == 3'h0);
    assign acc = hsel_in && hready_in && htrans_in[1];

    always_comb begin
        logic [31:0] rd;
        logic [3:0]  consec_n;
        logic        drive_n;
        rd       = 32'h0;
        consec_n = 4'h0;
        drive_n  = 1'b0;
        next_st  = st;

        case (st.dp_addr)
            `TATC_CTRL_OFS: begin
                rd[`TATC_CTRL_MODE_LSB +: 2] = st.mode;
                rd[`TATC_CTRL_EDGE_EN]       = st.edge_en;
                rd[`TATC_CTRL_CRIT_EN]       = st.crit_en;
            end
            `TATC_STATUS_OFS: begin
                rd[`TATC_ST_ALERT]           = alert_ext;
                rd[`TATC_ST_LOWPERF]         = (st.alert_st == TATC_AL_HELD);
                rd[`TATC_ST_CRIT]            = st.crit;
                rd[`TATC_ST_CRIT_STICKY]     = st.crit_sticky;
                rd[`TATC_ST_EV_ASSERT]       = st.ev_assert;
                rd[`TATC_ST_EV_DEASSERT]     = st.ev_deassert;
                rd[`TATC_ST_TRIP]            = st.trip;
                rd[`TATC_ST_DRIVE]           = st.drive;
                rd[`TATC_ST_DEMOTE_LSB +: 4] = st.demote;
            end
            `TATC_ODEM_OFS: begin
                rd[`TATC_OD_MSR_EN]            = st.msr_en;
                rd[`TATC_OD_MSR_DUTY_LSB +: 3] = st.msr_duty;
                rd[`TATC_OD_IO_EN]             = st.io_en;
                rd[`TATC_OD_IO_DUTY_LSB +: 3]  = st.io_duty;
            end
            `TATC_MEMCFG_OFS: begin
                rd[`TATC_MC_WARM_LSB +: 8]     = st.warm;
                rd[`TATC_MC_HOT_LSB +: 8]      = st.hot;
                rd[`TATC_MC_WARM_AMT_LSB +: 4] = st.warm_amt;
                rd[`TATC_MC_HOT_AMT_LSB +: 4]  = st.hot_amt;
            end
            `TATC_MEMSTAT_OFS: begin
                rd[`TATC_MS_LEVEL_LSB +: 2]    = st.mem.level;
                rd[`TATC_MS_AMT_LSB +: 4]      = st.mem.amount;
                rd[`TATC_MS_REFRESH]           = st.mem.refresh_double;
            end
            default: rd = 32'h0;
        endcase

        // Reads take one wait state so that read data leaves a flip-flop.
        if (st.dp_rd && !st.rd_rdy) begin
            next_st.rd_rdy = 1'b1;
            next_st.hrdata = rd;
        end
        if (st.dp_rd && st.rd_rdy) begin
            next_st.dp_rd  = 1'b0;
            next_st.rd_rdy = 1'b0;
        end

        if (st.dp_wr) begin
            next_st.dp_wr = 1'b0;
            case (st.dp_addr)
                `TATC_CTRL_OFS: begin
                    case (hwdata_in[`TATC_CTRL_MODE_LSB +: 2])
                        `TATC_MODE_CODE_OUT:   next_st.mode = TATC_MODE_OUT;
                        `TATC_MODE_CODE_BIDIR: next_st.mode = TATC_MODE_BIDIR;
                        default:               next_st.mode = TATC_MODE_IN;
                    endcase
                    next_st.edge_en = hwdata_in[`TATC_CTRL_EDGE_EN];
                    next_st.crit_en = hwdata_in[`TATC_CTRL_CRIT_EN];
                end
                `TATC_STATUS_OFS: begin
                    if (hwdata_in[`TATC_ST_CRIT_STICKY]) begin
                        next_st.crit_sticky = 1'b0;
                    end
                    if (hwdata_in[`TATC_ST_EV_ASSERT]) begin
                        next_st.ev_assert = 1'b0;
                    end
                    if (hwdata_in[`TATC_ST_EV_DEASSERT]) begin
                        next_st.ev_deassert = 1'b0;
                    end
                end
                `TATC_ODEM_OFS: begin
                    next_st.msr_en   = hwdata_in[`TATC_OD_MSR_EN];
                    next_st.msr_duty = hwdata_in[`TATC_OD_MSR_DUTY_LSB +: 3];
                    next_st.io_en    = hwdata_in[`TATC_OD_IO_EN];
                    next_st.io_duty  = hwdata_in[`TATC_OD_IO_DUTY_LSB +: 3];
                end
                `TATC_MEMCFG_OFS: begin
                    next_st.warm     = hwdata_in[`TATC_MC_WARM_LSB +: 8];
                    next_st.hot      = hwdata_in[`TATC_MC_HOT_LSB +: 8];
                    next_st.warm_amt = hwdata_in[`TATC_MC_WARM_AMT_LSB +: 4];
                    next_st.hot_amt  = hwdata_in[`TATC_MC_HOT_AMT_LSB +: 4];
                end
                default: next_st.dp_wr = 1'b0;
            endcase
        end

        if (acc) begin
            next_st.dp_wr   = hwrite_in;
            next_st.dp_rd   = !hwrite_in;
            next_st.rd_rdy  = 1'b0;
            next_st.dp_addr = haddr_in[7:0];
        end

        // Quiet-window countdown after a release; expiry raises the cap one step.
        if (st.alert_st == TATC_AL_IDLE && st.win != 24'h0) begin
            next_st.win = st.win - 24'h1;
            if (st.win == 24'h1) begin
                next_st.consec = 4'h0;
                if (st.demote != 4'h0) begin
                    next_st.demote = st.demote - 4'h1;
                end
                if (st.demote > 4'h1) begin
                    next_st.win = CONSEC_WINDOW_CYC[23:0];
                end
            end
        end

        // Events are applied after software clears, so a set in the same cycle wins.
        case (st.alert_st)
            TATC_AL_IDLE: begin
                if (alert_ext) begin
                    next_st.alert_st  = TATC_AL_HELD;
                    next_st.ev_assert = 1'b1;
                    consec_n = (st.win != 24'h0) ? st.consec + 4'h1 : 4'h1;
                    next_st.win = 24'h0;
                    if (consec_n >= `TATC_DEMOTE_THRESH) begin
                        next_st.consec = 4'h0;
                        if (st.demote != `TATC_DEMOTE_MAX) begin
                            next_st.demote = st.demote + 4'h1;
                        end
                    end else begin
                        next_st.consec = consec_n;
                    end
                end
            end
            TATC_AL_HELD: begin
                if (!alert_ext) begin
                    next_st.alert_st    = TATC_AL_IDLE;
                    next_st.ev_deassert = 1'b1;
                    next_st.win         = CONSEC_WINDOW_CYC[23:0];
                end
            end
            default: next_st.alert_st = TATC_AL_IDLE;
        endcase

        if (st.mode != TATC_MODE_IN) begin
            next_st.demote = 4'h0;
            next_st.consec = 4'h0;
            next_st.win    = 24'h0;
        end

        // Our own drive follows the circuit but drops during package idle.
        drive_n = (st.mode != TATC_MODE_IN) && tcc_active_in && !pkg_idle_in;
        next_st.drive = drive_n;
        if (st.drive && !drive_n) begin
            next_st.guard = `TATC_RELEASE_GUARD;
        end else if (st.guard != 3'h0) begin
            next_st.guard = st.guard - 3'h1;
        end

        next_st.crit = tcc_active_in && crit_temp_in;
        if (tcc_active_in && crit_temp_in) begin
            next_st.crit_sticky = 1'b1;
        end
        if (trip_temp_in) begin
            next_st.trip = 1'b1;
        end

        // The external alert is deliberately absent from the modulation request.
        next_st.clkmod.en = tcc_clkmod_in || st.io_en || st.msr_en;
        if (tcc_clkmod_in) begin
            next_st.clkmod.duty = `TATC_TCC_DUTY;
        end else if (st.io_en) begin
            next_st.clkmod.duty = st.io_duty;
        end else begin
            next_st.clkmod.duty = st.msr_duty;
        end
        next_st.clkmod.all_cores = st.io_en;

        if (mem_temp_in >= st.hot) begin
            next_st.mem.level  = 2'h2;
            next_st.mem.amount = st.hot_amt;
        end else if (mem_temp_in >= st.warm) begin
            next_st.mem.level  = 2'h1;
            next_st.mem.amount = st.warm_amt;
        end else begin
            next_st.mem.level  = 2'h0;
            next_st.mem.amount = 4'h0;
        end
        if (mr3_valid_in) begin
            next_st.mem.refresh_double = (mr3_temp_in >= `TATC_MR3_HOT_CODE);
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st          <= '0;
            st.mode     <= TATC_MODE_IN;
            st.alert_st <= TATC_AL_IDLE;
            st.warm     <= `TATC_WARM_RST;
            st.hot      <= `TATC_HOT_RST;
            st.warm_amt <= `TATC_WARM_AMT_RST;
            st.hot_amt  <= `TATC_HOT_AMT_RST;
        end else begin
            st <= next_st;
        end
    end

    assign hrdata_out             = st.hrdata;
    assign hreadyout_out          = !(st.dp_rd && !st.rd_rdy);
    assign hresp_out              = 1'b0;
    assign thermal_alert_n_out    = 1'b0;
    assign thermal_alert_n_oe_out = st.drive;
    assign lowest_perf_state_out  = (st.alert_st == TATC_AL_HELD);
    assign fast_half_freq_out     = (st.alert_st == TATC_AL_HELD) && (st.mode == TATC_MODE_IN);
    assign freq_demote_out        = st.demote;
    assign edge_irq_out           = st.edge_en && (st.ev_assert || st.ev_deassert);
    assign thermal_irq_out        = st.crit_en && st.crit_sticky;
    assign overtemp_trip_n_out    = !st.trip;
    assign pkg_shutdown_out       = st.trip;
    assign clkmod_out             = st.clkmod;
    assign mem_throttle_out       = st.mem;

    // Cycles since the filtered pin went low without a response yet.
    logic [15:0] lat_cnt;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !alert_ext || lowest_perf_state_out) begin
            lat_cnt <= 16'h0;
        end else begin
            lat_cnt <= lat_cnt + 16'h1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_alert_seen;
        alert_ext && !lowest_perf_state_out;
    endsequence
    sequence s_alert_gone;
        !alert_ext && lowest_perf_state_out;
    endsequence

    a_mode_after_reset: assert property ($past(sys_rst_in) |-> st.mode == TATC_MODE_IN)
        else $error("alert mode not input after reset");
    a_alert_low_perf: assert property (s_alert_seen |=> lowest_perf_state_out)
        else $error("external alert did not force lowest state");
    a_no_alert_clkmod: assert property (lowest_perf_state_out && !tcc_clkmod_in
        && !st.io_en && !st.msr_en |=> !clkmod_out.en)
        else $error("alert started clock modulation");
    a_hold_low_perf: assert property (lowest_perf_state_out && alert_ext
        |=> lowest_perf_state_out)
        else $error("lowest state left while alert held");
    a_release_edge_irq: assert property (s_alert_gone ##1 st.edge_en
        |-> edge_irq_out && st.ev_deassert)
        else $error("deassert edge interrupt missing");
    a_bidir_defer: assert property (thermal_alert_n_oe_out && !lowest_perf_state_out |=> !lowest_perf_state_out)
        else $error("external alert sensed while driving");
    a_fast_response: assert property (lat_cnt < 16'(`TATC_FAST_LIMIT_CYC))
        else $error("alert response too slow");
    a_demote_step: assert property (s_alert_seen ##0 (st.mode == TATC_MODE_IN)
        && (st.win != 24'h0) && (st.consec == `TATC_DEMOTE_THRESH - 4'h1)
        && (st.demote != `TATC_DEMOTE_MAX) |=> freq_demote_out == $past(st.demote) + 4'h1)
        else $error("demotion step missing");
    a_demote_input_only: assert property (st.mode != TATC_MODE_IN |=> freq_demote_out == 4'h0)
        else $error("demotion outside input mode");
    a_idle_release: assert property (pkg_idle_in |=> !thermal_alert_n_oe_out)
        else $error("alert driven during package idle");
    a_trip_latched: assert property (trip_temp_in |=> !overtemp_trip_n_out [*3])
        else $error("trip output not latched");
    a_crit_sticky: assert property (tcc_active_in && crit_temp_in ##1 !st.dp_wr
        |-> st.crit_sticky && (thermal_irq_out == st.crit_en))
        else $error("critical status not latched");
    a_tcc_duty: assert property (tcc_clkmod_in |=> clkmod_out.duty == `TATC_TCC_DUTY)
        else $error("circuit duty not applied");
    a_io_wins: assert property (!tcc_clkmod_in && st.io_en && st.msr_en
        |=> clkmod_out.duty == $past(st.io_duty) && clkmod_out.all_cores)
        else $error("I/O duty did not take precedence");
    a_mem_hot: assert property (mem_temp_in >= st.hot |=> mem_throttle_out.level == 2'h2)
        else $error("hot memory throttle missing");
    a_mr3_refresh: assert property (mr3_valid_in && mr3_temp_in >= `TATC_MR3_HOT_CODE
        |=> mem_throttle_out.refresh_double)
        else $error("refresh not raised from die temperature");
endmodule // tatc_core

`default_nettype wire

// ### tb/tatc_alert_src.sv
`timescale 1ns/1ps
`default_nettype none

// Platform controller that pulls the open-drain alert line low on request.
module tatc_alert_src (
    input  wire logic clk_in,
    input  wire logic hot_in,
    output var  logic pull_n_out
);
    initial pull_n_out = 1'b1;
    always @(posedge clk_in) begin
        pull_n_out <= ~hot_in;
    end
endmodule // tatc_alert_src

`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import tatc_pkg::*;
    logic clk = 0, rst = 1, sel = 0, wr = 0, hot = 0, tact = 0, tmod = 0, idle = 0;
    logic crit = 0, trip = 0, mv = 0, pull_n, al_o, al_oe, lp, half, eirq, tirq, trip_n, shut, rdy;
    logic [1:0] tr = 0, mt = 0;
    logic [7:0] mtemp = 0;
    logic [3:0] dem;
    logic [31:0] ad = 0, wd = 0, rd, r;
    logic [2:0] d1, d2;
    tatc_clkmod_s cm;
    tatc_mem_s mm;
    logic resp;
    int fails = 0, checks = 0, seed = 36966, cyc = 0;
    wire logic pin = pull_n & ~(al_oe & ~al_o);
    initial forever #4 clk = ~clk;
    tatc_alert_src src (.clk_in(clk), .hot_in(hot), .pull_n_out(pull_n));
    tatc_core #(.CONSEC_WINDOW_CYC(50)) dut (.clk_in(clk), .sys_rst_in(rst), .hsel_in(sel),
        .haddr_in(ad), .htrans_in(tr), .hwrite_in(wr), .hsize_in(3'h2), .hwdata_in(wd),
        .hready_in(rdy), .hrdata_out(rd), .hreadyout_out(rdy), .hresp_out(resp),
        .thermal_alert_n_in(pin), .thermal_alert_n_out(al_o), .thermal_alert_n_oe_out(al_oe),
        .tcc_active_in(tact), .tcc_clkmod_in(tmod), .pkg_idle_in(idle), .crit_temp_in(crit),
        .trip_temp_in(trip), .mem_temp_in(mtemp), .mr3_valid_in(mv), .mr3_temp_in(mt),
        .lowest_perf_state_out(lp), .fast_half_freq_out(half), .freq_demote_out(dem),
        .edge_irq_out(eirq), .thermal_irq_out(tirq), .overtemp_trip_n_out(trip_n),
        .pkg_shutdown_out(shut), .clkmod_out(cm), .mem_throttle_out(mm));
    task automatic summarize;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        sel <= 1; tr <= 2'h2; wr <= w; ad <= {24'h0, a};
        do @(posedge clk); while (rdy !== 1'b1);
        tr <= 2'h0; sel <= 0; wd <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        r = rd;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        wt(8); rst <= 0; wt(1);
        bus(0, 8'h00, 0); chk("ctrl_rst", r, 0);
        bus(0, 8'h0c, 0); chk("memcfg_rst", r, 32'h00f45f55);
        bus(0, 8'h14, 0); chk("unmapped", r, 0);
        chk("okay", resp, 0);
        for (int m = 0; m < 3; m++) begin
            bus(1, 8'h00, 32'h4 | m);
            for (int p = 0; p < 3; p++) begin
                hot <= 1; wt(12);
                chk("lowperf", lp, m != 1);
                chk("half", half, m == 0);
                chk("nomod", cm.en, 0);
                hot <= 0; wt(12);
                chk("release", lp, 0);
            end
            chk("demote", dem, m == 0);
            wt(300); chk("demote_up", dem, 0);
        end
        $display("alert mode test done");
        chk("edge_irq", eirq, 1);
        bus(1, 8'h04, 32'h30); wt(2); chk("edge_clr", eirq, 0);
        tact <= 1; hot <= 1; wt(20);
        chk("drive", al_oe, 1); chk("deferred", lp, 0);
        idle <= 1; mtemp <= 8'h60; wt(3);
        chk("idle_drop", al_oe, 0);
        chk("idle_poll", mm.level, 2'h2);
        idle <= 0; wt(3); chk("wake", al_oe, 1);
        tact <= 0; wt(20); chk("after_rel", lp, 1);
        hot <= 0; wt(20);
        $display("drive test done");
        bus(1, 8'h00, 32'h8); tact <= 1; crit <= 1; wt(4);
        chk("crit_irq", tirq, 1);
        tact <= 0; crit <= 0;
        for (int i = 0; i < 6; i++) begin
            d1 = (i == 0) ? 3'h7 : 3'($random(seed));
            d2 = (i == 0) ? 3'h0 : 3'($random(seed));
            if (d1 == 3'h2) d1 = 3'h6;
            bus(1, 8'h08, {24'h0, d2, 1'b1, d1, 1'b1}); wt(2);
            chk("io_wins", cm, {1'b1, d2, 1'b1});
            bus(1, 8'h08, {28'h0, d1, 1'b1}); tmod <= 1; wt(2);
            chk("tcc_duty", cm.duty, 3'h2);
            tmod <= 0; wt(2); chk("msr_duty", cm.duty, d1);
            mtemp <= 8'h60 + (8'($random(seed)) & 8'h1f); wt(3);
            chk("hot_amt", mm.amount, 4'hf);
            chk("hot_lvl", mm.level, 2'h2);
            mtemp <= 8'h55 + (8'($random(seed)) & 8'h07); wt(3);
            chk("warm_amt", mm.amount, 4'h4);
            chk("warm_lvl", mm.level, 2'h1);
            mv <= 1; mt <= 2'h2 + i[0]; wt(3);
            chk("refresh", mm.refresh_double, 1);
            mt <= 2'h1; wt(3); chk("refresh_n", mm.refresh_double, 0);
        end
        $display("modulation and memory test done");
        trip <= 1; wt(4);
        chk("trip", {trip_n, shut}, 2'b01);
        $display("all tests done");
        summarize();
    end
endmodule // tb_top

`default_nettype wire
